/* File: src/asp_defines.vh */
// Constants shared by the multichannel audio serial port design
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// APB byte offsets
`define ASP_A_CTRL 8'h00
`define ASP_A_SLOT 8'h04
`define ASP_A_TX0 8'h08
`define ASP_A_TX1 8'h0C
`define ASP_A_RX 8'h10
`define ASP_A_STAT 8'h14
`define ASP_A_CLK 8'h18
// Control register fields
`define ASP_C_EN 0
`define ASP_C_LJ 1
`define ASP_C_CTRLR 2
`define ASP_C_BINV 3
`define ASP_C_FINV 4
`define ASP_C_TRI 5
`define ASP_C_HOLD 6
`define ASP_C_LATE 7
`define ASP_C_WL 9:8
`define ASP_C_GP 11:10
`define ASP_C_SCTRL 12
`define ASP_C_IGN 13
// Slot register fields
`define ASP_S_TXSH 4:0
`define ASP_S_RXSH 12:8
`define ASP_S_TX0 20:16
`define ASP_S_TX1 28:24
// Clock register fields
`define ASP_K_DIV 7:0
`define ASP_K_RATIO 19:8
`define ASP_K_RXS 28:24
// Status register fields
`define ASP_T_ERR 0
`define ASP_T_RXR 1
`define ASP_T_LOCK 2
// Reset values
`define ASP_CTRL_RST 32'h0000_0000
`define ASP_SLOT_RST 32'h1000_0000
`define ASP_CLK_RST 32'h0000_4004
// General pin modes
`define ASP_GP_OFF 2'h0
`define ASP_GP_LANE 2'h1
`define ASP_GP_CHAIN 2'h2
`define ASP_GP_SEC 2'h3
// Word lengths in bit clocks
`define ASP_WL16 6'h10
`define ASP_WL20 6'h14
`define ASP_WL24 6'h18
`define ASP_WL32 6'h20
// Highest slot index per half frame
`define ASP_LAST_SLOT 4'hF
// Frame rate classes in kHz
`define ASP_FS0 10'h008
`define ASP_FS1 10'h010
`define ASP_FS2 10'h018
`define ASP_FS3 10'h020
`define ASP_FS4 10'h030
`define ASP_FS5 10'h060
`define ASP_FS6 10'h0C0
`define ASP_FS7 10'h180
`define ASP_FS8 10'h300
`define ASP_NCLASS 8
// Ratio limits and bit clock ceiling
`define ASP_R_MIN 12'h010
`define ASP_R_MAX 12'h800
`define ASP_R3_MIN 12'h008
`define ASP_R3_MAX 12'h080
`define ASP_R_NOLOW 12'h020
`define ASP_BCLK_MAX_KHZ 22'h00_6000
`define ASP_CLK_KHZ 125000
`endif

/* File: src/asp_core.v */
// Multichannel I2S / left-justified audio serial port with APB registers
// How it works
// (RULE1) I2S left MSB two falls after drop
// (RULE2) I2S right MSB two falls after rise
// (RULE3) Further slots follow slot 0 in order
// (RULE4) I2S sync and data change on fall
// (RULE5) Host gives enough bit clocks per frame
// (RULE6) I2S sync phases cover left, right slots
// (RULE7) LJ sync phases cover left, right slots
// (RULE8) LJ left MSB in rising sync cycle
// (RULE9) LJ right MSB in falling sync cycle
// (RULE10) LJ later bits and sync on fall
// (RULE11) Host prefers nonzero shift at speed
// (RULE12) Channels map to any of 32 slots
// (RULE13) Optional release in unused slots
// (RULE14) Optional holder keeps last data level
// (RULE15) Late latching adds one bit clock
// (RULE16) Ports may run controller or target
// (RULE17) General pins: lane, port or chain
// (RULE18) Measure rates, derive clocking unaided
// (RULE19) Accept listed ratios and rate classes
// (RULE20) Refuse combinations beyond bit clock ceiling
// (RULE21) Bad combination flags error and mutes
// (RULE22) Separate 0..31 slot start shifts
// (RULE23) Bit clock and sync invert bits
// (RULE24) Release from unassigned slot until assigned
`timescale 1ns/100ps
`include "asp_defines.vh"
module asp_core #(
  parameter CLK_KHZ = `ASP_CLK_KHZ
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_bit_clock,
  output wire o_bit_clock,
  output wire o_bit_clock_oe_n,
  input wire i_frame_sync,
  output wire o_frame_sync,
  output wire o_frame_sync_oe_n,
  input wire i_data,
  output wire o_data,
  output wire o_data_oe_n,
  output wire o_data_hold,
  output wire o_data_hold_oe_n,
  input wire i_general_input_pin,
  output wire o_general_output_pin,
  input wire i_general_pin_io,
  output wire o_general_pin_io,
  output wire o_general_pin_io_oe_n,
  output wire o_mute
);
  // Word length decode, used by both slot counters, the transmit bit select and receive completion
  function [5:0] wl_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wl_of = `ASP_WL16;
        2'h1: wl_of = `ASP_WL20;
        2'h2: wl_of = `ASP_WL24;
        default: wl_of = `ASP_WL32;
      endcase
    end
  endfunction
  // Nominal frame rate of a class in kHz
  function [9:0] fs_of;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: fs_of = `ASP_FS0;
        4'h1: fs_of = `ASP_FS1;
        4'h2: fs_of = `ASP_FS2;
        4'h3: fs_of = `ASP_FS3;
        4'h4: fs_of = `ASP_FS4;
        4'h5: fs_of = `ASP_FS5;
        4'h6: fs_of = `ASP_FS6;
        4'h7: fs_of = `ASP_FS7;
        default: fs_of = `ASP_FS8;
      endcase
    end
  endfunction
  // Supported ratios are 2^k or 3*2^k inside fixed bounds
  function ratio_ok;
    input [11:0] r;
    reg [11:0] q;
    begin
      q = r / 12'h003;
      ratio_ok = (((r & (r - 12'h001)) == 12'h000) &&
                  r >= `ASP_R_MIN && r <= `ASP_R_MAX) ||
                 ((q * 12'h003 == r) && ((q & (q - 12'h001)) == 12'h000) &&
                  q >= `ASP_R3_MIN && q <= `ASP_R3_MAX);
    end
  endfunction

  reg [31:0] ctrl_ff, slot_ff, clk_ff, tx0_ff, tx1_ff, rx_ff, prdata_ff;
  reg err_ff, rxr_ff, mute_ff, locked_ff, started_ff;
  reg [4:0] s1_ff, s2_ff;
  reg [7:0] div_cnt_ff;
  reg gen_bclk_ff, gen_fs_ff, bq_ff, left_q_ff, resync_ff;
  reg [11:0] fcnt_ff, cnt_r_ff, ratio_ff, half_ff;
  reg [16:0] clk_cnt_ff;
  reg [3:0] rate_ff, idx;
  reg [31:0] txsh0_ff, txsh1_ff, rxsh_ff;
  reg data_ff, data_oe_n_ff, last_ff, gpo_ff;
  integer i;

  wire en = ctrl_ff[`ASP_C_EN];
  wire lj = ctrl_ff[`ASP_C_LJ];
  wire ctrlr = ctrl_ff[`ASP_C_CTRLR];
  wire [1:0] gp = ctrl_ff[`ASP_C_GP];
  wire [5:0] wl = wl_of(ctrl_ff[`ASP_C_WL]);

  // APB slave: zero wait states, error on unmapped offsets
  wire mapped = (i_paddr == `ASP_A_CTRL) || (i_paddr == `ASP_A_SLOT) ||
                (i_paddr == `ASP_A_TX0) || (i_paddr == `ASP_A_TX1) ||
                (i_paddr == `ASP_A_RX) || (i_paddr == `ASP_A_STAT) ||
                (i_paddr == `ASP_A_CLK);
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite & mapped;
  wire rd_rx = acc & ~i_pwrite & (i_paddr == `ASP_A_RX);
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata = prdata_ff;

  // Pins from outside the clock domain pass two flops first
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
    end else begin
      s1_ff <= {i_general_pin_io, i_general_input_pin, i_data,
                i_frame_sync, i_bit_clock};
      s2_ff <= s1_ff;
    end
  end

  // Standard-polarity bit clock and sync, own or received
  wire bclk_std = ctrlr ? gen_bclk_ff
                        : s2_ff[0] ^ ctrl_ff[`ASP_C_BINV]; // see (RULE23)
  wire fs_std = ctrlr ? gen_fs_ff
                      : s2_ff[1] ^ ctrl_ff[`ASP_C_FINV]; // see (RULE23)
  wire rise = bclk_std & ~bq_ff;
  wire fall = ~bclk_std & bq_ff;
  wire left_now = lj ? fs_std : ~fs_std;
  wire start_seen = rise & left_now & ~left_q_ff;
  wire right_seen = rise & ~left_now & left_q_ff;
  wire [11:0] flen = ctrlr ? clk_ff[`ASP_K_RATIO] : ratio_ff;
  wire [11:0] half = ctrlr ? {1'b0, flen[11:1]}
                           : half_ff; // see (RULE6) see (RULE7)
  wire [11:0] nxt_fcnt = resync_ff ? 12'h001 :
                         (fcnt_ff + 12'h001 >= flen) ? 12'h000 :
                         fcnt_ff + 12'h001;
  // Position one fall ahead, so a bit is armed before it must leave
  wire [11:0] la = (nxt_fcnt + 12'h001 >= flen) ? 12'h000 :
                   nxt_fcnt + 12'h001;

  // Controller clock divider; sync changes on the falling edge
  wire div_hit = ({1'b0, div_cnt_ff} + 9'h001) >= {1'b0, clk_ff[`ASP_K_DIV]};
  always @(posedge i_clk) begin
    if (!i_rstn || !en || !ctrlr) begin
      div_cnt_ff <= 8'h00;
      gen_bclk_ff <= 1'b0;
      gen_fs_ff <= 1'b0;
    end else begin
      div_cnt_ff <= div_hit ? 8'h00 : div_cnt_ff + 8'h01;
      if (div_hit)
        gen_bclk_ff <= ~gen_bclk_ff; // see (RULE16)
      if (fall)
        gen_fs_ff <= (nxt_fcnt < half) ~^ lj; // see (RULE4) see (RULE10)
    end
  end
  assign o_bit_clock = gen_bclk_ff ^ ctrl_ff[`ASP_C_BINV];
  assign o_frame_sync = gen_fs_ff ^ ctrl_ff[`ASP_C_FINV];
  assign o_bit_clock_oe_n = ~(en & ctrlr); // see (RULE16)
  assign o_frame_sync_oe_n = ~(en & ctrlr);

  // Frame tracking: the frame counter predicts the next sync edge so
  // the first bit can leave on the very edge the sync changes on
  always @(posedge i_clk) begin
    if (!i_rstn || !en) begin
      bq_ff <= 1'b0;
      left_q_ff <= 1'b0;
      resync_ff <= 1'b0;
      fcnt_ff <= 12'h000;
      cnt_r_ff <= 12'h000;
      ratio_ff <= 12'h000;
      half_ff <= 12'h000;
    end else begin
      bq_ff <= bclk_std;
      if (rise) begin
        left_q_ff <= left_now;
        cnt_r_ff <= start_seen ? 12'h001 : cnt_r_ff + 12'h001;
        if (start_seen)
          ratio_ff <= cnt_r_ff;
        if (right_seen)
          half_ff <= cnt_r_ff;
      end
      // A sync edge seen in the wrong place realigns on the next fall
      if (start_seen && !ctrlr && fcnt_ff != 12'h000)
        resync_ff <= 1'b1;
      else if (fall)
        resync_ff <= 1'b0;
      if (fall)
        fcnt_ff <= nxt_fcnt;
    end
  end

  // Rate class from system clocks per frame, thresholds at midpoints
  always @* begin
    idx = 4'h0;
    for (i = 0; i < `ASP_NCLASS; i = i + 1) begin
      if ({15'h0000, clk_cnt_ff} < (CLK_KHZ * 2) /
          (fs_of(i[3:0]) + fs_of(i[3:0] + 4'h1)))
        idx = i[3:0] + 4'h1;
    end
  end
  wire [21:0] bclk_khz = cnt_r_ff * fs_of(idx);
  wire bad = ~ratio_ok(cnt_r_ff) || // see (RULE19)
             (bclk_khz > `ASP_BCLK_MAX_KHZ) || // see (RULE20)
             (idx == 4'h0 && cnt_r_ff < `ASP_R_NOLOW); // see (RULE20)

  // Auto-detection runs once per frame on the measured figures
  always @(posedge i_clk) begin
    if (!i_rstn || !en) begin
      clk_cnt_ff <= 17'h0_0000;
      rate_ff <= 4'h0;
      started_ff <= 1'b0;
      locked_ff <= 1'b0;
      mute_ff <= 1'b0;
    end else if (start_seen) begin
      clk_cnt_ff <= 17'h0_0001;
      started_ff <= 1'b1;
      if (started_ff) begin
        rate_ff <= idx; // see (RULE18)
        locked_ff <= ~bad;
        mute_ff <= bad & ~ctrl_ff[`ASP_C_IGN]; // see (RULE21)
      end
    end else if (clk_cnt_ff != 17'h1_FFFF) begin
      clk_cnt_ff <= clk_cnt_ff + 17'h0_0001;
    end
  end
  assign o_mute = mute_ff;

  // One slot walker for transmit (0) and receive (1), each with its shift
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_path
      reg act_ff, lr_ff;
      reg [3:0] sl_ff;
      reg [4:0] bit_ff;
      wire [5:0] shift = (p == 0) ? {1'b0, slot_ff[`ASP_S_TXSH]} :
                         {1'b0, slot_ff[`ASP_S_RXSH]} +
                         {5'h00, ctrl_ff[`ASP_C_LATE]}; // see (RULE15)
      wire [11:0] st_l = {11'h000, ~lj} + {6'h00, shift}; // see (RULE22)
      wire [11:0] st_r = half + st_l;
      // Transmit arms a fall early since its bit leaves a fall later
      wire [11:0] pos = (p == 0) ? la : nxt_fcnt;
      always @(posedge i_clk) begin
        if (!i_rstn || !en) begin
          act_ff <= 1'b0;
          lr_ff <= 1'b0;
          sl_ff <= 4'h0;
          bit_ff <= 5'h00;
        end else if (fall) begin
          if (pos == st_l || pos == st_r) begin
            act_ff <= 1'b1; // see (RULE1) see (RULE2) see (RULE8) see (RULE9)
            lr_ff <= (pos == st_r);
            sl_ff <= 4'h0;
            bit_ff <= 5'h00;
          end else if (act_ff) begin
            if ({1'b0, bit_ff} == wl - 6'h01) begin
              bit_ff <= 5'h00;
              sl_ff <= sl_ff + 4'h1; // see (RULE3)
              if (sl_ff == `ASP_LAST_SLOT)
                act_ff <= 1'b0;
            end else begin
              bit_ff <= bit_ff + 5'h01;
            end
          end
        end
      end
    end
  endgenerate

  // Transmit selection: a channel owns the slot whose code it holds
  wire [4:0] tx_code = {g_path[0].lr_ff, g_path[0].sl_ff};
  wire [4:0] rx_code = {g_path[1].lr_ff, g_path[1].sl_ff};
  wire [4:0] nb = 5'h1F - g_path[0].bit_ff - (5'h1F - wl[4:0] + 5'h01);
  wire sel0 = g_path[0].act_ff & (tx_code == slot_ff[`ASP_S_TX0]);
  wire sel1 = g_path[0].act_ff & (tx_code == slot_ff[`ASP_S_TX1]);
  wire main1 = sel1 & (gp != `ASP_GP_LANE);
  wire own = sel0 | main1; // see (RULE12)

  // Serial outputs change only on the falling bit clock edge
  always @(posedge i_clk) begin
    if (!i_rstn || !en) begin
      txsh0_ff <= 32'h0000_0000;
      txsh1_ff <= 32'h0000_0000;
      data_ff <= 1'b0;
      data_oe_n_ff <= 1'b1;
      last_ff <= 1'b0;
      gpo_ff <= 1'b0;
    end else if (fall) begin
      // Words are taken just before the frame's first bit can leave
      if (la == 12'h000) begin
        txsh0_ff <= tx0_ff;
        txsh1_ff <= tx1_ff;
      end
      data_ff <= ~mute_ff & own &
                 (sel0 ? txsh0_ff[nb] : txsh1_ff[nb]); // see (RULE4)
      // Unused slots drive low unless release is enabled
      data_oe_n_ff <= ~own & ctrl_ff[`ASP_C_TRI]; // see (RULE13) see (RULE24)
      if (!(~own & ctrl_ff[`ASP_C_TRI]))
        last_ff <= ~mute_ff & own & (sel0 ? txsh0_ff[nb] : txsh1_ff[nb]);
      case (gp)
        `ASP_GP_LANE: gpo_ff <= ~mute_ff & sel1 & txsh1_ff[nb]; // see (RULE17)
        `ASP_GP_CHAIN: gpo_ff <= s2_ff[3]; // see (RULE17)
        default: gpo_ff <= 1'b0;
      endcase
    end
  end
  assign o_data = data_ff;
  assign o_data_oe_n = data_oe_n_ff | ~en;
  // Holder drives the last driven level only while data is released and the hold bit is set
  assign o_data_hold = last_ff;
  assign o_data_hold_oe_n = ~((data_oe_n_ff | ~en) &
                              ctrl_ff[`ASP_C_HOLD]); // see (RULE14)
  // Secondary port mode carries clock on the pin and sync on the output
  wire sec = en & (gp == `ASP_GP_SEC) & ctrl_ff[`ASP_C_SCTRL];
  assign o_general_pin_io = o_bit_clock;
  assign o_general_pin_io_oe_n = ~sec; // see (RULE16) see (RULE17)
  assign o_general_output_pin = (gp == `ASP_GP_SEC) ? o_frame_sync : gpo_ff;

  // Receive capture on the rising bit clock edge, muted on clock error
  wire rx_hit = rise & g_path[1].act_ff & ~mute_ff &
                (rx_code == clk_ff[`ASP_K_RXS]);
  wire [31:0] rx_next = (g_path[1].bit_ff == 5'h00) ? {31'h0, s2_ff[2]} :
                        {rxsh_ff[30:0], s2_ff[2]};
  wire rx_done = rx_hit & ({1'b0, g_path[1].bit_ff} == wl - 6'h01);

  // Register file; hardware set of a flag wins over its clear
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_ff <= `ASP_CTRL_RST;
      slot_ff <= `ASP_SLOT_RST;
      clk_ff <= `ASP_CLK_RST;
      tx0_ff <= 32'h0000_0000;
      tx1_ff <= 32'h0000_0000;
      rx_ff <= 32'h0000_0000;
      rxsh_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      rxr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (wr && i_paddr == `ASP_A_CTRL)
        ctrl_ff <= i_pwdata;
      if (wr && i_paddr == `ASP_A_SLOT)
        slot_ff <= i_pwdata;
      if (wr && i_paddr == `ASP_A_CLK)
        clk_ff <= i_pwdata;
      if (wr && i_paddr == `ASP_A_TX0)
        tx0_ff <= i_pwdata;
      if (wr && i_paddr == `ASP_A_TX1)
        tx1_ff <= i_pwdata;
      if (rx_hit)
        rxsh_ff <= rx_next;
      if (rx_done)
        rx_ff <= rx_next;
      if (start_seen && started_ff && bad && !ctrl_ff[`ASP_C_IGN])
        err_ff <= 1'b1; // see (RULE21)
      else if (wr && i_paddr == `ASP_A_STAT && i_pwdata[`ASP_T_ERR])
        err_ff <= 1'b0;
      if (rx_done)
        rxr_ff <= 1'b1;
      else if (rd_rx)
        rxr_ff <= 1'b0;
      // Read data is loaded in the setup phase for the access phase
      if (i_psel && !i_penable) begin
        case (i_paddr)
          `ASP_A_CTRL: prdata_ff <= ctrl_ff;
          `ASP_A_SLOT: prdata_ff <= slot_ff;
          `ASP_A_CLK: prdata_ff <= clk_ff;
          `ASP_A_TX0: prdata_ff <= tx0_ff;
          `ASP_A_TX1: prdata_ff <= tx1_ff;
          `ASP_A_RX: prdata_ff <= rx_ff;
          `ASP_A_STAT: prdata_ff <= {4'h0, ratio_ff, 8'h00, rate_ff, 1'b0,
                                     locked_ff, rxr_ff, err_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // asp_core

/* File: bench/asp_core_monitor.sv */
// Concurrent checks on the serial port pins and the register bus
`timescale 1ns/100ps
module asp_core_monitor (
  input wire i_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire [7:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire i_bit_clock,
  input wire o_bit_clock,
  input wire o_bit_clock_oe_n,
  input wire o_frame_sync,
  input wire o_frame_sync_oe_n,
  input wire o_data,
  input wire o_data_oe_n,
  input wire o_data_hold
);
  reg [3:0] since_fall_ff;
  reg bclk_q_ff;
  wire [3:0] nxt_since_fall;
  default clocking mon_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Cycles since the bit clock pin fell; saturates so idle never wraps
  assign nxt_since_fall = (bclk_q_ff && !i_bit_clock) ? 4'h0 :
    (since_fall_ff == 4'hF) ? 4'hF : since_fall_ff + 4'h1;
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      since_fall_ff <= 4'hF;
      bclk_q_ff <= 1'b0;
    end else begin
      since_fall_ff <= nxt_since_fall;
      bclk_q_ff <= i_bit_clock;
    end
  end
  // Register bus refusals
  a_unmapped_err: assert property (
    i_psel && i_penable && i_paddr > 8'h18 |-> o_pslverr)
    else $error("unmapped access not refused");
  a_unmapped_zero: assert property (
    o_pslverr |-> o_prdata == 32'h0000_0000)
    else $error("refused read returned data");
  // Target data moves only shortly after a bit clock fall
  a_data_fall: assert property (
    $changed(o_data) && !o_data_oe_n && o_bit_clock_oe_n
    |-> since_fall_ff inside {[1:6]})
    else $error("data changed away from a falling edge");
  a_sync_fall: assert property (
    !o_frame_sync_oe_n && $changed(o_frame_sync) |-> !o_bit_clock)
    else $error("frame sync moved while bit clock high");
  // Controller clock keeps its half period of four system clocks
  a_bclk_half: assert property (
    $rose(o_bit_clock) && !o_bit_clock_oe_n
    |=> (o_bit_clock || o_bit_clock_oe_n) [*3])
    else $error("bit clock high phase too short");
  a_clock_pair: assert property (
    o_bit_clock_oe_n == o_frame_sync_oe_n)
    else $error("bit clock and frame sync drive differ");
  // Keeper follows the driven level and stands while released
  a_hold_follow: assert property (
    !o_data_oe_n |-> o_data_hold == o_data)
    else $error("holder missed driven level");
  a_hold_stable: assert property (
    o_data_oe_n && $past(o_data_oe_n) |-> $stable(o_data_hold))
    else $error("holder changed while released");
  // A release lasts at least seven system clocks
  a_release_span: assert property (
    $rose(o_data_oe_n) |=> o_data_oe_n [*6])
    else $error("data release shorter than a bit");
endmodule // asp_core_monitor

bind asp_core asp_core_monitor u_mon (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_bit_clock(i_bit_clock),
  .o_bit_clock(o_bit_clock), .o_bit_clock_oe_n(o_bit_clock_oe_n),
  .o_frame_sync(o_frame_sync), .o_frame_sync_oe_n(o_frame_sync_oe_n),
  .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_data_hold(o_data_hold));

/* File: bench/asp_host_model.sv */
// Host bus model: makes bit clock and frame sync, samples the data line
`timescale 1ns/100ps
module asp_host_model #(
  parameter HALF = 8
) (
  input wire i_clk,
  input wire i_run,
  input wire i_lj,
  input wire i_data,
  input wire i_data_oe_n,
  input wire i_data_hold,
  input wire i_data_hold_oe_n,
  output reg o_bit_clock = 1'b0,
  output reg o_frame_sync = 1'b0,
  output reg [63:0] o_bits = 64'h0,
  output reg [63:0] o_drv = 64'h0,
  output reg [31:0] o_frames = 32'h0
);
  integer div = 0;
  integer idx = 63;
  reg [63:0] bits_ff = 64'h0;
  reg [63:0] drv_ff = 64'h0;
  reg last_ff = 1'b0;
  wire line;
  // A released line with no keeper shows the inverse of its last level
  assign line = !i_data_oe_n ? i_data :
    (!i_data_hold_oe_n ? i_data_hold : ~last_ff);
  // Sixty-four bit clocks a frame, half each phase
  always @(posedge i_clk) begin
    if (!i_run) begin
      o_bit_clock <= 1'b0;
      div <= 0;
    end else if (div < HALF - 1) begin
      div <= div + 1;
    end else begin
      div <= 0;
      o_bit_clock <= ~o_bit_clock;
      if (o_bit_clock) begin
        // Sync moves only as the clock falls
        idx <= (idx == 63) ? 0 : idx + 1;
        o_frame_sync <= (idx >= 31 && idx != 63) ^ i_lj;
      end else begin
        // Sample the resolved line as the clock rises
        bits_ff[63 - idx] <= line;
        drv_ff[63 - idx] <= !i_data_oe_n;
        last_ff <= line;
        if (idx == 63) begin
          o_bits <= {bits_ff[63:1], line};
          o_drv <= {drv_ff[63:1], !i_data_oe_n};
          o_frames <= o_frames + 32'h1;
        end
      end
    end
  end
endmodule // asp_host_model

/* File: bench/asp_core_tb.sv */
// Self-checking bench for the audio serial port
`timescale 1ns/100ps
`include "asp_defines.vh"
module asp_core_tb;
  reg i_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg run = 1'b1;
  reg lj = 1'b0;
  reg [31:0] q;
  reg e;
  reg [63:0] b, m;
  integer fails = 0;
  integer tests_run = 0;
  wire [31:0] prdata, frames;
  wire pready, pslverr, obclk, bclk_oe_n, ofs, fs_oe_n, odata, doe_n;
  wire dhold, hoe_n, h_bclk, h_fs;
  wire [63:0] bits, drv;
  // Pin levels: whoever has its enable low owns the wire
  wire bclk_w = bclk_oe_n ? h_bclk : obclk;
  wire fs_w = fs_oe_n ? h_fs : ofs;
  always #4 i_clk = ~i_clk;
  asp_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_bit_clock(bclk_w), .o_bit_clock(obclk),
    .o_bit_clock_oe_n(bclk_oe_n), .i_frame_sync(fs_w), .o_frame_sync(ofs),
    .o_frame_sync_oe_n(fs_oe_n), .i_data(odata), .o_data(odata),
    .o_data_oe_n(doe_n), .o_data_hold(dhold), .o_data_hold_oe_n(hoe_n),
    .i_general_input_pin(1'b0), .o_general_output_pin(),
    .i_general_pin_io(1'b0), .o_general_pin_io(),
    .o_general_pin_io_oe_n(), .o_mute());
  asp_host_model #(.HALF(8)) host (.i_clk(i_clk), .i_run(run), .i_lj(lj),
    .i_data(odata), .i_data_oe_n(doe_n), .i_data_hold(dhold),
    .i_data_hold_oe_n(hoe_n), .o_bit_clock(h_bclk), .o_frame_sync(h_fs),
    .o_bits(bits), .o_drv(drv), .o_frames(frames));
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task timeout;
    begin
      fails = fails + 1;
      $display("ERROR t=%0t wait limit ran out", $time);
      give_verdict;
    end
  endtask
  task check(input [63:0] got, input [63:0] exp, input string s);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR t=%0t %s got %h exp %h", $time, s, got, exp);
      end
    end
  endtask
  // One APB transfer; an idle cycle after keeps psel from toggling twice
  task apb(input reg wr, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge i_clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge i_clk);
        n = n + 1;
      end
      if (n == 20) timeout;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  // Place a 16-bit word at a bit position of the 64-bit frame
  function [63:0] at(input [15:0] w, input integer p);
    at = {48'h0, w} << (48 - p);
  endfunction
  // Reconfigure, let the port realign, then take one whole frame
  task frame_run(input [31:0] ctrl, input [31:0] slot);
    integer f0;
    integer n;
    begin
      apb(1'b1, `ASP_A_CTRL, 32'h0000_0000);
      apb(1'b1, `ASP_A_SLOT, slot);
      apb(1'b1, `ASP_A_TX0, 32'h0000_A5C3);
      apb(1'b1, `ASP_A_TX1, 32'h0000_3C5B);
      apb(1'b1, `ASP_A_CTRL, ctrl);
      lj <= ctrl[`ASP_C_LJ];
      f0 = frames;
      n = 0;
      while (frames < f0 + 4 && n < 9000) begin
        @(posedge i_clk);
        n = n + 1;
      end
      if (n == 9000) timeout;
      b = bits;
      m = drv;
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, `ASP_A_CTRL, 32'h0000_0000);
      check(q, `ASP_CTRL_RST, "ctrl reset");
      apb(1'b0, `ASP_A_SLOT, 32'h0000_0000);
      check(q, `ASP_SLOT_RST, "slot reset");
      apb(1'b0, `ASP_A_CLK, 32'h0000_0000);
      check(q, `ASP_CLK_RST, "clk reset");
      apb(1'b0, 8'h1C, 32'h0000_0000);
      check({q, 31'h0, e}, 64'h1, "unmapped read");
    end
  endtask
  task t_i2s;
    begin
      frame_run(32'h0000_2001, `ASP_SLOT_RST);
      check(b, at(16'hA5C3, 1) | at(16'h3C5B, 33), "i2s");
      check(m, 64'hFFFF_FFFF_FFFF_FFFF, "i2s drive");
      apb(1'b0, `ASP_A_STAT, 32'h0000_0000);
      check(q & 32'h0FFF_000F, 32'h0040_0006, "status");
      apb(1'b0, `ASP_A_RX, 32'h0000_0000);
      check(q, 32'h0000_A5C3, "loopback rx");
    end
  endtask
  task t_lj;
    begin
      frame_run(32'h0000_2003, `ASP_SLOT_RST);
      check(b, at(16'hA5C3, 0) | at(16'h3C5B, 32), "lj");
    end
  endtask
  // Left slot 1 and right slot 0, both pushed two bits late
  task t_order;
    begin
      frame_run(32'h0000_2003, 32'h1001_0002);
      check(b, at(16'hA5C3, 18) | at(16'h3C5B, 34), "order");
    end
  endtask
  // Released slots keep the last driven LSB through the keeper
  task t_tri;
    begin
      frame_run(32'h0000_2063, `ASP_SLOT_RST);
      check(m, 64'hFFFF_0000_FFFF_0000, "release");
      check(b, at(16'hA5C3, 0) | at(16'h3C5B, 32) |
        64'h0000_FFFF_0000_FFFF, "keeper");
    end
  endtask
  // Controller mode: host stops its clock, the port makes its own
  task t_ctrl;
    integer n;
    integer k;
    reg prev;
    begin
      run <= 1'b0;
      apb(1'b1, `ASP_A_CTRL, 32'h0000_2005);
      repeat (100) @(posedge i_clk);
      // Sample the pin mid-cycle, away from the edge that moves it
      @(negedge i_clk);
      k = 0;
      prev = obclk;
      for (n = 0; n < 800; n = n + 1) begin
        @(negedge i_clk);
        k = k + (obclk !== prev);
        prev = obclk;
      end
      @(posedge i_clk);
      check({bclk_oe_n, fs_oe_n}, 64'h0, "ctrl drive");
      check(k, 800 / (`ASP_CLK_RST & 32'h0000_00FF), "bclk");
      apb(1'b1, `ASP_A_CTRL, 32'h0000_0000);
      run <= 1'b1;
    end
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    t_regs;
    t_i2s;
    t_lj;
    t_order;
    t_tri;
    t_ctrl;
    give_verdict;
  end
endmodule // asp_core_tb
